// [core/rhtq_regs.sv]
// Receive header status, byte count and transmit queue command registers.
`timescale 1ns/1ps
`include "rhtq_map.svh"

module rhtq_regs (
    input  wire  logic                    ref_clk,
    input  wire  logic                    nrst,
    input  wire  rhtq_pkg::rhtq_reg_req_t req,
    output logic [15:0]                   rdata,
    input  wire  rhtq_pkg::rhtq_rx_frame_t rx_head,
    output logic                          rx_pop,
    output logic                          rx_drop,
    input  wire  logic                    tx_frame_ready,
    input  wire  logic                    tx_done,
    output logic                          tx_enqueue,
    input  wire  logic [12:0]             tx_mem_avail,
    input  wire  logic [12:0]             tx_size_request,
    output logic                          mem_irq_set,
    output logic                          pass_bad_out
);
    import rhtq_pkg::*;

    logic [15:0]    txq_cmd_reg, txq_cmd_next;
    logic [15:0]    rx_ctl_reg, rx_ctl_next;
    logic [15:0]    rdata_reg, rdata_next;
    logic           pop_reg, pop_next;
    logic           drop_reg, drop_next;
    logic           enq_reg, enq_next;
    logic           irq_reg, irq_next;
    rhtq_tx_state_t tx_state_reg, tx_state_next;
    logic [15:0]    hdr_status;
    logic           deliver;

    function automatic logic hit(input rhtq_reg_req_t r, input logic [7:0] off);
        hit = (r.addr[7:1] == off[7:1]);
    endfunction

    rhtq_hdr_status u_hdr (
        .frame   (rx_head),
        .pass_bad(rx_ctl_reg[`RHTQ_BIT_PASS_BAD]),
        .status  (hdr_status),
        .deliver (deliver)
    );

    // ------------------------------------------------------------
    // Receive side
    // ------------------------------------------------------------
    always_comb begin
        rdata_next = rdata_reg;
        pop_next   = 1'b0;
        drop_next  = 1'b0;
        rx_ctl_next = rx_ctl_reg;
        if (req.wr && hit(req, `RHTQ_OFF_RX_CONTROL)) begin
            rx_ctl_next = req.wdata;
        end
        if (rx_head.valid && !deliver && !drop_reg) begin
            drop_next = 1'b1;
        end
        if (req.rd) begin
            if (hit(req, `RHTQ_OFF_RX_HDR_STATUS)) begin
                rdata_next = (rx_head.valid && deliver) ? hdr_status : 16'h0000;
            end else if (hit(req, `RHTQ_OFF_RX_HDR_COUNT)) begin
                rdata_next = (rx_head.valid && deliver) ?
                             {4'h0, rx_head.byte_count} : 16'h0000;
                pop_next   = rx_head.valid && deliver;
            end else if (hit(req, `RHTQ_OFF_TX_QUEUE_CMD)) begin
                rdata_next = txq_cmd_reg;
            end else if (hit(req, `RHTQ_OFF_RX_CONTROL)) begin
                rdata_next = rx_ctl_reg;
            end else begin
                rdata_next = 16'h0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Transmit queue command
    // ------------------------------------------------------------
    always_comb begin
        txq_cmd_next  = txq_cmd_reg;
        tx_state_next = tx_state_reg;
        enq_next      = 1'b0;
        irq_next      = 1'b0;
        if (req.wr && hit(req, `RHTQ_OFF_TX_QUEUE_CMD)) begin
            txq_cmd_next = {13'h0000, req.wdata[2:0]};
        end
        if (txq_cmd_reg[`RHTQ_BIT_MEM_MONITOR] && tx_mem_avail >= tx_size_request) begin
            irq_next = 1'b1;
            txq_cmd_next[`RHTQ_BIT_MEM_MONITOR] = 1'b0;
        end
        unique case (tx_state_reg)
            RHTQ_TX_IDLE: begin
                if (tx_frame_ready && (txq_cmd_reg[`RHTQ_BIT_AUTO_ENQ] ||
                                       txq_cmd_reg[`RHTQ_BIT_MANUAL_ENQ])) begin
                    enq_next      = 1'b1;
                    tx_state_next = RHTQ_TX_SEND;
                end
            end
            RHTQ_TX_SEND: begin
                tx_state_next = RHTQ_TX_WAIT;
            end
            RHTQ_TX_WAIT: begin
                if (tx_done) begin
                    txq_cmd_next[`RHTQ_BIT_MANUAL_ENQ] = 1'b0;
                    tx_state_next = RHTQ_TX_IDLE;
                end
            end
            default: begin
                tx_state_next = RHTQ_TX_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Receive registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rx_ctl_reg   <= `RHTQ_RX_CONTROL_RESET;
            rdata_reg    <= 16'h0000;
            pop_reg      <= 1'b0;
            drop_reg     <= 1'b0;
        end else begin
            rx_ctl_reg   <= rx_ctl_next;
            rdata_reg    <= rdata_next;
            pop_reg      <= pop_next;
            drop_reg     <= drop_next;
        end
    end

    // ------------------------------------------------------------
    // Transmit registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            txq_cmd_reg  <= `RHTQ_TXQ_CMD_RESET;
            enq_reg      <= 1'b0;
            irq_reg      <= 1'b0;
            tx_state_reg <= RHTQ_TX_IDLE;
        end else begin
            txq_cmd_reg  <= txq_cmd_next;
            enq_reg      <= enq_next;
            irq_reg      <= irq_next;
            tx_state_reg <= tx_state_next;
        end
    end

    assign rdata        = rdata_reg;
    assign rx_pop       = pop_reg;
    assign rx_drop      = drop_reg;
    assign tx_enqueue   = enq_reg;
    assign mem_irq_set  = irq_reg;
    assign pass_bad_out = rx_ctl_reg[`RHTQ_BIT_PASS_BAD];

    // ------------------------------------------------------------
    // Receive checks
    // ------------------------------------------------------------
    // Header reads answer one cycle late, so the frame is looked at through $past.
    a_type_bit: assert property (@(posedge ref_clk) disable iff (!nrst)
        $past(req.rd && hit(req, `RHTQ_OFF_RX_HDR_STATUS) && rx_head.valid && deliver)
        |-> rdata[`RHTQ_BIT_FRAME_TYPE] == $past(rx_head.length_type > `RHTQ_TYPE_LIMIT))
        else $error("frame type bit wrong");

    a_too_long_bit: assert property (@(posedge ref_clk) disable iff (!nrst)
        $past(req.rd && hit(req, `RHTQ_OFF_RX_HDR_STATUS) && rx_head.valid && deliver)
        |-> rdata[`RHTQ_BIT_TOO_LONG] == $past(rx_head.byte_count > `RHTQ_MAX_FRAME_BYTES))
        else $error("too-long bit wrong");

    a_count_whole: assert property (@(posedge ref_clk) disable iff (!nrst)
        $past(req.rd && hit(req, `RHTQ_OFF_RX_HDR_COUNT) && rx_head.valid && deliver)
        |-> rdata[`RHTQ_COUNT_MSB:0] == $past(rx_head.byte_count))
        else $error("byte count truncated");

    a_bad_withheld: assert property (@(posedge ref_clk) disable iff (!nrst)
        (rx_head.valid && rx_head.byte_count > 12'h7d0 && !pass_bad_out && !drop_reg)
        |=> rx_drop) else $error("oversized frame not withheld");

    a_pass_delivers: assert property (@(posedge ref_clk) disable iff (!nrst)
        (rx_head.valid && pass_bad_out) |=> !rx_drop)
        else $error("frame withheld although pass-bad is set");

    a_drop_only_bad: assert property (@(posedge ref_clk) disable iff (!nrst)
        rx_drop |-> $past(rx_head.valid && !deliver))
        else $error("drop of a deliverable frame");

    a_runt_withheld: assert property (@(posedge ref_clk) disable iff (!nrst)
        (rx_head.valid && rx_head.runt && !pass_bad_out && !rx_drop) |=> rx_drop)
        else $error("runt frame not withheld");

    a_runt_bit: assert property (@(posedge ref_clk) disable iff (!nrst)
        $past(req.rd && hit(req, `RHTQ_OFF_RX_HDR_STATUS) && rx_head.valid && deliver)
        |-> rdata[`RHTQ_BIT_RUNT] == $past(rx_head.runt))
        else $error("runt bit wrong");

    a_crc_withheld: assert property (@(posedge ref_clk) disable iff (!nrst)
        (rx_head.valid && rx_head.crc_error && !pass_bad_out && !rx_drop) |=> rx_drop)
        else $error("crc error frame not withheld");

    a_crc_bit: assert property (@(posedge ref_clk) disable iff (!nrst)
        $past(req.rd && hit(req, `RHTQ_OFF_RX_HDR_STATUS) && rx_head.valid && deliver)
        |-> rdata[`RHTQ_BIT_CRC_ERROR] == $past(rx_head.crc_error))
        else $error("crc error bit wrong");

    a_count_upper: assert property (@(posedge ref_clk) disable iff (!nrst)
        $past(req.rd && hit(req, 8'h7e)) |-> rdata[15:12] == 4'h0)
        else $error("byte count reserved bits not zero");

    a_pop_once: assert property (@(posedge ref_clk) disable iff (!nrst)
        rx_pop |-> $past(req.rd && hit(req, 8'h7e))) else $error("pop without count read");

    a_pop_delivered: assert property (@(posedge ref_clk) disable iff (!nrst)
        rx_pop |-> $past(rx_head.valid && deliver))
        else $error("pop of a frame that was not delivered");

    a_status_no_pop: assert property (@(posedge ref_clk) disable iff (!nrst)
        $past(req.rd && hit(req, `RHTQ_OFF_RX_HDR_STATUS)) |-> !rx_pop)
        else $error("status read consumed the frame");

    a_valid_bit: assert property (@(posedge ref_clk) disable iff (!nrst)
        ($past(req.rd && hit(req, 8'h7c)) && rdata[15]) |-> $past(rx_head.valid))
        else $error("valid bit without complete frame");

    a_valid_low_idle: assert property (@(posedge ref_clk) disable iff (!nrst)
        $past(req.rd && hit(req, `RHTQ_OFF_RX_HDR_STATUS) && !rx_head.valid)
        |-> rdata == 16'h0000)
        else $error("header status shown without a frame");

    a_pass_written: assert property (@(posedge ref_clk) disable iff (!nrst)
        $past(req.wr && hit(req, `RHTQ_OFF_RX_CONTROL))
        |-> pass_bad_out == $past(req.wdata[`RHTQ_BIT_PASS_BAD]))
        else $error("pass-bad bit not written");

    // ------------------------------------------------------------
    // Transmit checks
    // ------------------------------------------------------------
    a_enq_one_pulse: assert property (@(posedge ref_clk) disable iff (!nrst)
        tx_enqueue |=> !tx_enqueue) else $error("enqueue pulse longer than one cycle");

    a_enq_needs_cmd: assert property (@(posedge ref_clk) disable iff (!nrst)
        tx_enqueue |-> $past(txq_cmd_reg[`RHTQ_BIT_MANUAL_ENQ] || txq_cmd_reg[`RHTQ_BIT_AUTO_ENQ]))
        else $error("enqueue without a command bit");

    a_enq_idle_only: assert property (@(posedge ref_clk) disable iff (!nrst)
        (tx_state_reg != RHTQ_TX_IDLE) |=> !tx_enqueue)
        else $error("enqueue while a frame is in flight");

    a_manual_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
        (tx_state_reg == RHTQ_TX_WAIT && tx_done) |=> !txq_cmd_reg[0])
        else $error("manual bit not cleared after transmit");

    a_manual_held: assert property (@(posedge ref_clk) disable iff (!nrst)
        (txq_cmd_reg[`RHTQ_BIT_MANUAL_ENQ] && !(tx_state_reg == RHTQ_TX_WAIT && tx_done) &&
         !(req.wr && hit(req, `RHTQ_OFF_TX_QUEUE_CMD))) |=> txq_cmd_reg[`RHTQ_BIT_MANUAL_ENQ])
        else $error("manual bit dropped before transmit finished");

    a_auto_enqueue: assert property (@(posedge ref_clk) disable iff (!nrst)
        (tx_state_reg == RHTQ_TX_IDLE && tx_frame_ready && txq_cmd_reg[2]) |=> tx_enqueue)
        else $error("auto enqueue missed a frame");

    a_enq_needs_frame: assert property (@(posedge ref_clk) disable iff (!nrst)
        tx_enqueue |-> $past(tx_frame_ready))
        else $error("enqueue without a prepared frame");

    a_mon_irq: assert property (@(posedge ref_clk) disable iff (!nrst)
        (txq_cmd_reg[1] && tx_mem_avail >= tx_size_request) |=> mem_irq_set)
        else $error("memory monitor interrupt missing");

    a_irq_needs_mon: assert property (@(posedge ref_clk) disable iff (!nrst)
        mem_irq_set |-> $past(txq_cmd_reg[`RHTQ_BIT_MEM_MONITOR]))
        else $error("memory interrupt without monitor request");

    a_mon_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
        mem_irq_set |-> !txq_cmd_reg[1]) else $error("monitor bit not cleared");

    a_mon_held: assert property (@(posedge ref_clk) disable iff (!nrst)
        (txq_cmd_reg[`RHTQ_BIT_MEM_MONITOR] && tx_mem_avail < tx_size_request &&
         !(req.wr && hit(req, `RHTQ_OFF_TX_QUEUE_CMD))) |=> txq_cmd_reg[`RHTQ_BIT_MEM_MONITOR])
        else $error("monitor bit dropped before memory was free");

endmodule

// [core/rhtq_map.svh]
// Register offsets, field positions, reset values and limits of the header and enqueue registers.
`ifndef RHTQ_MAP_SVH
`define RHTQ_MAP_SVH

`define RHTQ_ADDR_W            8
`define RHTQ_OFF_RX_HDR_STATUS 8'h7c
`define RHTQ_OFF_RX_HDR_COUNT  8'h7e
`define RHTQ_OFF_TX_QUEUE_CMD  8'h80
`define RHTQ_OFF_RX_CONTROL    8'h74

`define RHTQ_BIT_FRAME_VALID   15
`define RHTQ_BIT_FRAME_TYPE    3
`define RHTQ_BIT_TOO_LONG      2
`define RHTQ_BIT_RUNT          1
`define RHTQ_BIT_CRC_ERROR     0
`define RHTQ_BIT_MANUAL_ENQ    0
`define RHTQ_BIT_MEM_MONITOR   1
`define RHTQ_BIT_AUTO_ENQ      2
`define RHTQ_BIT_PASS_BAD      0

`define RHTQ_COUNT_MSB         11
`define RHTQ_TYPE_LIMIT        16'h05dc
`define RHTQ_MAX_FRAME_BYTES   12'h7d0
`define RHTQ_TXQ_CMD_RESET     16'h0000
`define RHTQ_RX_CONTROL_RESET  16'h0000
`define RHTQ_ISR_MEM_BIT       6

`endif

// [core/rhtq_pkg.sv]
// Types shared by the header status and transmit enqueue register logic.
package rhtq_pkg;

    typedef struct packed {
        logic        valid;
        logic        crc_error;
        logic        runt;
        logic [15:0] length_type;
        logic [11:0] byte_count;
        logic [15:0] upper_status;
    } rhtq_rx_frame_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } rhtq_reg_req_t;

    typedef enum logic [2:0] {
        RHTQ_TX_IDLE = 3'b001,
        RHTQ_TX_SEND = 3'b010,
        RHTQ_TX_WAIT = 3'b100
    } rhtq_tx_state_t;

endpackage

// [core/rhtq_hdr_status.sv]
// Builds the header status word and the delivery decision of one received frame.
`timescale 1ns/1ps
`include "rhtq_map.svh"

module rhtq_hdr_status (
    input  wire rhtq_pkg::rhtq_rx_frame_t frame,
    input  wire logic                     pass_bad,
    output logic [15:0]                   status,
    output logic                          deliver
);
    import rhtq_pkg::*;

    logic too_long;
    logic bad;

    always_comb begin
        too_long = frame.byte_count > `RHTQ_MAX_FRAME_BYTES;
        bad      = too_long | frame.runt | frame.crc_error;
        status   = {frame.upper_status[15:4], 4'h0};
        status[`RHTQ_BIT_FRAME_VALID] = frame.valid;
        status[`RHTQ_BIT_FRAME_TYPE]  = frame.length_type > `RHTQ_TYPE_LIMIT;
        status[`RHTQ_BIT_TOO_LONG]    = too_long;
        status[`RHTQ_BIT_RUNT]        = frame.runt;
        status[`RHTQ_BIT_CRC_ERROR]   = frame.crc_error;
        deliver = frame.valid & (~bad | pass_bad);
    end

endmodule

// [test/rhtq_partner.sv]
// Receive queue head and transmit engine that face the register block.
`timescale 1ns/1ps
module rhtq_partner (
    input  wire logic                     ref_clk,
    input  wire logic                     nrst,
    input  wire logic                     load,
    input  wire rhtq_pkg::rhtq_rx_frame_t nxt,
    output rhtq_pkg::rhtq_rx_frame_t      rx_head,
    input  wire logic                     rx_pop,
    input  wire logic                     rx_drop,
    input  wire logic                     tx_enqueue,
    input  wire logic                     mem_irq_set,
    output logic                          tx_done,
    output int                            pops,
    output int                            drops,
    output int                            enqs,
    output int                            irqs
);
    import rhtq_pkg::*;
    int busy;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rx_head <= '0;
            tx_done <= 1'b0;
            busy <= 0;
            pops <= 0;
            drops <= 0;
            enqs <= 0;
            irqs <= 0;
        end else begin
            // An empty head alternates between the inverted and the plain fields of the last frame, with valid low.
            if (load)
                rx_head <= nxt;
            else if (rx_pop || rx_drop || !rx_head.valid)
                rx_head <= {1'b0, ~rx_head[$bits(rx_head)-2:0]};
            pops <= pops + int'(rx_pop);
            drops <= drops + int'(rx_drop);
            enqs <= enqs + int'(tx_enqueue);
            irqs <= irqs + int'(mem_irq_set);
            busy <= tx_enqueue ? 6 : (busy > 0 ? busy - 1 : 0);
            tx_done <= (busy == 1);
        end
    end
endmodule

// [test/rx_header_tx_enqueue_regs_test.sv]
// Self-checking bench of the header status and transmit enqueue registers.
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
    $display("wrong value at %0t: %h %h", $time, a, b); end end
module rx_header_tx_enqueue_regs_test;
    import rhtq_pkg::*;
    logic ref_clk = 0, nrst = 0, load = 0, tx_done, rx_pop, rx_drop, tx_enqueue, irq, pb;
    logic tx_frame_ready = 0, pass_bad_out;
    logic [12:0] tx_mem_avail = 13'h0ff, tx_size_request = 13'h100;
    logic [15:0] rdata, d, e;
    logic [31:0] r = 32'h0b4d;
    rhtq_reg_req_t req = '0;
    rhtq_rx_frame_t nxt = '0, rx_head, f;
    int errors = 0, checks_done = 0, pops, drops, enqs, irqs, p_exp = 0, d_exp = 0, e0;
    rhtq_regs dut (.ref_clk(ref_clk), .nrst(nrst), .req(req), .rdata(rdata),
        .rx_head(rx_head), .rx_pop(rx_pop), .rx_drop(rx_drop),
        .tx_frame_ready(tx_frame_ready), .tx_done(tx_done), .tx_enqueue(tx_enqueue),
        .tx_mem_avail(tx_mem_avail), .tx_size_request(tx_size_request),
        .mem_irq_set(irq), .pass_bad_out(pass_bad_out));
    rhtq_partner far (.ref_clk(ref_clk), .nrst(nrst), .load(load), .nxt(nxt),
        .rx_head(rx_head), .rx_pop(rx_pop), .rx_drop(rx_drop), .tx_enqueue(tx_enqueue),
        .mem_irq_set(irq), .tx_done(tx_done), .pops(pops), .drops(drops), .enqs(enqs),
        .irqs(irqs));
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [15:0] exp_st(rhtq_rx_frame_t x, logic p);
        logic bad;
        bad = x.crc_error | x.runt | (x.byte_count > 12'd2000);
        if (!x.valid || (bad && !p))
            return 16'h0000;
        return {1'b1, x.upper_status[14:4], x.length_type > 16'd1500,
            x.byte_count > 12'd2000, x.runt, x.crc_error};
    endfunction
    task automatic acc(logic w, logic [7:0] a, logic [15:0] wd);
        @(negedge ref_clk);
        req = '{wr: w, rd: !w, addr: a, wdata: wd};
        @(negedge ref_clk);
        req = '0;
        d = rdata;
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wait_clear(logic [15:0] m);
        for (int i = 0; i <= 60; i++) begin
            acc(0, 8'h80, 0);
            if ((d & m) === 16'h0000)
                return;
        end
        errors++;
        give_verdict();
    endtask
    initial begin
        repeat (2) @(negedge ref_clk);
        nrst = 1;
        acc(0, 8'h80, 0);
        `CHK(d, 16'h0000)
        acc(0, 8'h74, 0);
        `CHK(d, 16'h0000)
        acc(0, 8'h7c, 0);
        `CHK(d, 16'h0000)
        acc(1, 8'h90, 16'hffff);
        acc(0, 8'h90, 0);
        `CHK(d, 16'h0000)
        for (int i = 0; i < 16; i++) begin
            pb = (i >= 8);
            acc(1, 8'h74, {15'h0, pb});
            `CHK(pass_bad_out, pb)
            r = lfsr(lfsr(r));
            f = '{valid: 1'b1, crc_error: r[0] & r[1], runt: r[2] & r[3],
                length_type: r[4] ? 16'd1500 + r[5] : r[31:16],
                byte_count: r[6] ? 12'd2000 + r[7] : r[27:16], upper_status: r[15:0]};
            @(negedge ref_clk);
            nxt = f;
            load = 1;
            @(negedge ref_clk);
            load = 0;
            repeat (3) @(negedge ref_clk);
            acc(0, 8'h7c, 0);
            `CHK(d, exp_st(f, pb))
            e = exp_st(f, pb);
            `CHK(d[2], e[2])
            `CHK(d[1], e[1])
            `CHK(d[0], e[0])
            acc(0, 8'h7e, 0);
            `CHK(d, exp_st(f, pb) != 0 ? {4'h0, f.byte_count} : 16'h0000)
            if (exp_st(f, pb) != 0)
                p_exp++;
            else
                d_exp++;
            repeat (2) @(negedge ref_clk);
            `CHK(pops, p_exp)
            `CHK(drops, d_exp)
        end
        tx_frame_ready = 1;
        acc(1, 8'h80, 16'h0001);
        acc(0, 8'h80, 0);
        `CHK(d, 16'h0001)
        tx_frame_ready = 0;
        wait_clear(16'h0001);
        `CHK(enqs, 1)
        tx_frame_ready = 1;
        acc(1, 8'h80, 16'h0004);
        repeat (30) @(negedge ref_clk);
        `CHK(enqs > 3, 1'b1)
        acc(1, 8'h80, 16'h0000);
        tx_frame_ready = 0;
        repeat (10) @(negedge ref_clk);
        e0 = enqs;
        repeat (20) @(negedge ref_clk);
        `CHK(enqs, e0)
        acc(1, 8'h80, 16'h0002);
        repeat (4) @(negedge ref_clk);
        acc(0, 8'h80, 0);
        `CHK(d, 16'h0002)
        `CHK(irqs, 0)
        tx_mem_avail = 13'h100;
        wait_clear(16'h0002);
        `CHK(irqs, 1)
        give_verdict();
    end
endmodule
